// [mem_ecc_pkg.sv]
// Package for the memory error-correction monitor: register map, field positions,
// reset values and code widths.
// Assumes a 32-bit AXI4-Lite slave where each 8-bit register takes one aligned word.
package mem_ecc_pkg;
  // Printed offsets are not multiples of four, so they are indices; byte address = 4*index.
  localparam logic [15:0] PCFG_IDX = 16'hA00D;
  localparam logic [15:0] PADL_IDX = 16'hA00E;
  localparam logic [15:0] PADH_IDX = 16'hA00F;
  localparam logic [15:0] RCMD_IDX = 16'hA017;
  localparam logic [15:0] DCFG_IDX = 16'hA02D;
  localparam logic [15:0] DADL_IDX = 16'hA02E;
  localparam logic [15:0] DADH_IDX = 16'hA02F;
  // Field positions shared by both configuration registers.
  localparam int EN_BIT = 7;
  localparam int UIE_BIT = 5;
  localparam int CIE_BIT = 4;
  localparam int UF_BIT = 1;
  localparam int CF_BIT = 0;
  // Reset-command register: reset enable for uncorrectable fetch, flag, flag clear.
  localparam int RST_EN_BIT = 6;
  localparam int RST_CLR_BIT = 4;
  localparam int RST_FLAG_BIT = 2;
  localparam logic [7:0] CFG_RESET = 8'h80;
  localparam logic [7:0] ADL_RESET = 8'h00;
  localparam logic [7:0] ADH_RESET = 8'h80;
  localparam int DATA_DEPTH = 2048;
  localparam int DATA_CHECK_W = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [mem_ecc_monitor.sv]
// Error-correction monitor for the data SRAM and the program flash fetch path.
// Assumes the CPU, data memory and flash run on clk; software uses AXI4-Lite.
`timescale 1ns/1ps

// Behaviour
// - Data bytes stored as 13-bit coded words.
// - Data reads correct single, detect double errors.
// - Uncorrectable data read latches address, interrupts.
// - Data config resets to 0x80.
// - Corrected data returned; software rewrites it.
// - Data fault address frozen while flag set.
// - Flash word: low instruction, high check.
// - Check nibbles protect matching instruction nibbles.
// - Each nibble corrects one, detects two.
// - Fetch delivers corrected value, optional interrupt.
// - Uncorrectable fetch: interrupt or software reset.
// - Fetch fault address latched on errors.
// - Program config resets to 0x80.
// - Uncorrectable program flag sticky until cleared.
// - Correctable program flag sticky until cleared.
// - Program fault address holds latest error.
// - Program fault address top bits read zero.
// - Reset-enable bit selects reset response.
// - Correction disabled: controller reads return raw.
module mem_ecc_monitor #(
  parameter int ADDR_W = 11
) (
  input wire logic clk,
  input wire logic rst_n,
  // Data memory port from the CPU.
  input wire logic dmem_req,
  input wire logic dmem_we,
  input wire logic [ADDR_W-1:0] dmem_addr,
  input wire logic [7:0] dmem_wdata,
  output logic [7:0] dmem_rdata,
  output logic dmem_rvalid,
  // Program fetch port.
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic [15:0] fetch_word,
  output logic [7:0] fetch_instr,
  output logic fetch_instr_valid,
  // Flash controller read path.
  input wire logic fc_valid,
  input wire logic [15:0] fc_word,
  output logic [15:0] fc_rdata,
  output logic fc_rvalid,
  output logic data_corr_irq,
  output logic data_uncorr_irq,
  output logic prog_corr_irq,
  output logic prog_uncorr_irq,
  output logic ecc_soft_reset,
  // AXI4-Lite slave.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Hamming(12,8) plus overall parity gives single correction, double detection.
  function automatic logic [4:0] sec_ded_enc(input logic [7:0] d);
    logic [4:0] c;
    c[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
    c[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
    c[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
    c[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
    c[4] = ^d ^ c[0] ^ c[1] ^ c[2] ^ c[3];
    return c;
  endfunction

  // Returns {uncorrectable, corrected, data}.
  function automatic logic [9:0] sec_ded_dec(input logic [12:0] w);
    logic [4:0] s;
    logic [3:0] pos;
    logic [11:0] cw;
    logic [7:0] d;
    logic perr;
    s = sec_ded_enc(w[7:0]) ^ w[12:8];
    perr = ^w;
    cw = {w[7:4], w[11], w[3:1], w[10], w[0], w[9], w[8]};
    pos = s[3:0];
    if (perr && pos != 4'h0 && pos <= 4'hC) begin
      cw[pos-4'h1] = ~cw[pos-4'h1];
    end
    d = {cw[11:8], cw[6:4], cw[2]};
    sec_ded_dec = {(!perr && pos != 4'h0), perr, d};
  endfunction

  // Extended Hamming(8,4) per nibble: {uncorrectable, corrected, nibble}.
  function automatic logic [5:0] nib_dec(input logic [3:0] d, input logic [3:0] c);
    logic [2:0] s;
    logic [6:0] cw;
    logic perr;
    s[0] = c[0] ^ d[0] ^ d[1] ^ d[3];
    s[1] = c[1] ^ d[0] ^ d[2] ^ d[3];
    s[2] = c[2] ^ d[1] ^ d[2] ^ d[3];
    perr = ^{d, c};
    cw = {d[3], d[2], d[1], c[2], d[0], c[1], c[0]};
    if (perr && s != 3'h0) begin
      cw[s-3'h1] = ~cw[s-3'h1];
    end
    nib_dec = {(!perr && s != 3'h0), perr, cw[6], cw[5], cw[4], cw[2]};
  endfunction

  logic rst_s1_reg, rst_sync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_sync_n <= rst_s1_reg;
    end
  end

  logic [7:0] dcfg_reg, pcfg_reg;
  logic [15:0] dfault_reg;
  logic [13:0] pfault_reg;
  logic rst_en_reg, rst_flag_reg;

  logic [12:0] dmem_array [mem_ecc_pkg::DATA_DEPTH];
  logic rd_pend_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [12:0] rd_word_reg;
  always_ff @(posedge clk) begin
    if (dmem_req && dmem_we && dcfg_reg[mem_ecc_pkg::EN_BIT]) begin
      dmem_array[dmem_addr] <= {sec_ded_enc(dmem_wdata), dmem_wdata};
    end else if (dmem_req && dmem_we) begin
      // Unchecked writes leave stale check bits, so a mode switch corrupts words.
      dmem_array[dmem_addr][7:0] <= dmem_wdata;
    end
    rd_word_reg <= dmem_array[dmem_addr];
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= '0;
    end else begin
      rd_pend_reg <= dmem_req && !dmem_we;
      rd_addr_reg <= dmem_addr;
    end
  end

  logic [9:0] dres;
  logic d_en, d_ce, d_ue;
  assign dres = sec_ded_dec(rd_word_reg);
  assign d_en = dcfg_reg[mem_ecc_pkg::EN_BIT];
  assign d_ce = rd_pend_reg && d_en && dres[8];
  assign d_ue = rd_pend_reg && d_en && dres[9];

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dmem_rdata <= 8'h00;
      dmem_rvalid <= 1'b0;
    end else begin
      dmem_rvalid <= rd_pend_reg;
      dmem_rdata <= d_en ? dres[7:0] : rd_word_reg[7:0];
    end
  end

  logic [5:0] f_hi, f_lo;
  logic f_ce, f_ue;
  assign f_hi = nib_dec(fetch_word[7:4], fetch_word[15:12]);
  assign f_lo = nib_dec(fetch_word[3:0], fetch_word[11:8]);
  assign f_ue = fetch_valid && (f_hi[5] || f_lo[5]);
  assign f_ce = fetch_valid && !f_ue && (f_hi[4] || f_lo[4]);

  logic [5:0] c_hi, c_lo;
  assign c_hi = nib_dec(fc_word[7:4], fc_word[15:12]);
  assign c_lo = nib_dec(fc_word[3:0], fc_word[11:8]);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fetch_instr <= 8'h00;
      fetch_instr_valid <= 1'b0;
      fc_rdata <= 16'h0000;
      fc_rvalid <= 1'b0;
    end else begin
      fetch_instr_valid <= fetch_valid;
      fetch_instr <= {f_hi[3:0], f_lo[3:0]};
      fc_rvalid <= fc_valid;
      if (pcfg_reg[mem_ecc_pkg::EN_BIT]) begin
        fc_rdata <= {fc_word[15:8], c_hi[3:0], c_lo[3:0]};
      end else begin
        fc_rdata <= fc_word;
      end
    end
  end

  // AXI4-Lite write side: address and data taken in either order.
  logic aw_held_reg, w_held_reg;
  logic [15:0] aw_idx_reg;
  logic [7:0] wdat_reg;
  logic wstrb_reg;
  logic do_wr;
  assign do_wr = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= 16'h0000;
      wdat_reg <= 8'h00;
      wstrb_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mem_ecc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[17:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdat_reg <= s_axi_wdata[7:0];
        wstrb_reg <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_idx_reg) ? mem_ecc_pkg::RESP_OKAY
                                             : mem_ecc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic is_mapped(input logic [15:0] idx);
    is_mapped = idx inside {mem_ecc_pkg::PCFG_IDX, mem_ecc_pkg::PADL_IDX,
                            mem_ecc_pkg::PADH_IDX, mem_ecc_pkg::RCMD_IDX,
                            mem_ecc_pkg::DCFG_IDX, mem_ecc_pkg::DADL_IDX,
                            mem_ecc_pkg::DADH_IDX};
  endfunction

  logic wr_ok;
  assign wr_ok = do_wr && wstrb_reg;

  // Writing a flag as 1 keeps it; writing 0 clears it. A new event wins over the clear.
  function automatic logic [7:0] cfg_next(input logic [7:0] cur, input logic hit,
                                          input logic ce, input logic ue);
    logic [7:0] n;
    n = cur;
    if (hit) begin
      n = {wdat_reg[7], 1'b0, wdat_reg[5:4], 2'b00, wdat_reg[1:0] & cur[1:0]};
    end
    n[mem_ecc_pkg::CF_BIT] = n[mem_ecc_pkg::CF_BIT] | ce;
    n[mem_ecc_pkg::UF_BIT] = n[mem_ecc_pkg::UF_BIT] | ue;
    return n;
  endfunction

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dcfg_reg <= mem_ecc_pkg::CFG_RESET;
    end else begin
      dcfg_reg <= cfg_next(dcfg_reg, wr_ok && aw_idx_reg == mem_ecc_pkg::DCFG_IDX,
                           d_ce, d_ue);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pcfg_reg <= mem_ecc_pkg::CFG_RESET;
    end else begin
      pcfg_reg <= cfg_next(pcfg_reg, wr_ok && aw_idx_reg == mem_ecc_pkg::PCFG_IDX,
                           f_ce, f_ue);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dfault_reg <= {mem_ecc_pkg::ADH_RESET, mem_ecc_pkg::ADL_RESET};
    end else if ((d_ce || d_ue) && dcfg_reg[1:0] == 2'b00) begin
      dfault_reg <= 16'(rd_addr_reg);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pfault_reg <= 14'h0000;
    end else if (f_ce || f_ue) begin
      pfault_reg <= fetch_addr[13:0];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rst_en_reg <= 1'b0;
      rst_flag_reg <= 1'b0;
      ecc_soft_reset <= 1'b0;
    end else begin
      if (wr_ok && aw_idx_reg == mem_ecc_pkg::RCMD_IDX) begin
        rst_en_reg <= wdat_reg[mem_ecc_pkg::RST_EN_BIT];
        if (wdat_reg[mem_ecc_pkg::RST_CLR_BIT]) begin
          rst_flag_reg <= 1'b0;
        end
      end
      ecc_soft_reset <= f_ue && rst_en_reg;
      if (f_ue && rst_en_reg) begin
        rst_flag_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      data_corr_irq <= 1'b0;
      data_uncorr_irq <= 1'b0;
      prog_corr_irq <= 1'b0;
      prog_uncorr_irq <= 1'b0;
    end else begin
      data_corr_irq <= dcfg_reg[mem_ecc_pkg::CF_BIT] && dcfg_reg[mem_ecc_pkg::CIE_BIT];
      data_uncorr_irq <= dcfg_reg[mem_ecc_pkg::UF_BIT] && dcfg_reg[mem_ecc_pkg::UIE_BIT];
      prog_corr_irq <= pcfg_reg[mem_ecc_pkg::CF_BIT] && pcfg_reg[mem_ecc_pkg::CIE_BIT];
      prog_uncorr_irq <= pcfg_reg[mem_ecc_pkg::UF_BIT] && pcfg_reg[mem_ecc_pkg::UIE_BIT]
                         && !rst_en_reg;
    end
  end

  // AXI4-Lite read side; one read at a time.
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    unique case (s_axi_araddr[17:2])
      mem_ecc_pkg::PCFG_IDX: rd_val = pcfg_reg;
      mem_ecc_pkg::PADL_IDX: rd_val = pfault_reg[7:0];
      mem_ecc_pkg::PADH_IDX: rd_val = {2'b00, pfault_reg[13:8]};
      mem_ecc_pkg::RCMD_IDX: rd_val = {5'h00, rst_flag_reg, 2'b00};
      mem_ecc_pkg::DCFG_IDX: rd_val = dcfg_reg;
      mem_ecc_pkg::DADL_IDX: rd_val = dfault_reg[7:0];
      mem_ecc_pkg::DADH_IDX: rd_val = dfault_reg[15:8];
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= mem_ecc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_val};
        s_axi_rresp <= is_mapped(s_axi_araddr[17:2]) ? mem_ecc_pkg::RESP_OKAY
                                                     : mem_ecc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// [mem_ecc_assertions.sv]
// Port checker for the memory error-correction monitor.
// Assumes it is bound into every instance of the monitor and sees only its ports.
`timescale 1ns/1ps
module mem_ecc_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dmem_req,
  input wire logic dmem_we,
  input wire logic dmem_rvalid,
  input wire logic fetch_valid,
  input wire logic fetch_instr_valid,
  input wire logic fc_valid,
  input wire logic fc_rvalid,
  input wire logic prog_uncorr_irq,
  input wire logic ecc_soft_reset,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic rdq;
  assign rdq = dmem_req & ~dmem_we;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_FETCH_LAT: assert property (fetch_valid |=> fetch_instr_valid)
    else $error("fetch answer missing");
  AST_FC_LAT: assert property (fc_valid |=> fc_rvalid)
    else $error("flash read answer missing");
  AST_DMEM_READ: assert property (rdq |-> ##2 dmem_rvalid)
    else $error("data read answer missing");
  AST_SOFT_RST_SRC: assert property (ecc_soft_reset |-> $past(fetch_valid))
    else $error("reset pulse without fetch");
  AST_SOFT_RST_MASK: assert property (ecc_soft_reset |=> !prog_uncorr_irq)
    else $error("interrupt raised with reset response");
  AST_BVALID_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RVALID_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule

bind mem_ecc_monitor mem_ecc_chk u_chk (.clk, .rst_n, .dmem_req, .dmem_we, .dmem_rvalid,
  .fetch_valid, .fetch_instr_valid, .fc_valid, .fc_rvalid, .prog_uncorr_irq, .ecc_soft_reset,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// [mem_ecc_flash_model.sv]
// Program flash model: shows one coded word per request, with chosen bits flipped.
// Assumes instr and flip are set together with the request at a clock edge.
`timescale 1ns/1ps
module mem_ecc_flash_model (
  input wire logic clk,
  input wire logic req,
  input wire logic [7:0] instr,
  input wire logic [15:0] flip,
  output logic [15:0] word
);
  logic [15:0] good;
  logic [15:0] last;
  function automatic logic [3:0] nib(input logic [3:0] d);
    logic [2:0] c;
    c = {d[1] ^ d[2] ^ d[3], d[0] ^ d[2] ^ d[3], d[0] ^ d[1] ^ d[3]};
    return {^{c, d}, c};
  endfunction
  assign good = {nib(instr[7:4]), nib(instr[3:0]), instr} ^ flip;
  // Between requests the bus shows the inverse of the last word, flips included, so it decodes clean only if that word had none.
  assign word = req ? good : ~last;
  always_ff @(posedge clk) begin
    if (req) begin
      last <= good;
    end
  end
endmodule

// [tb.sv]
// Self-checking bench for the memory error-correction monitor.
// Assumes a 40 MHz clock and that registers are reached only over AXI4-Lite.
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, dmem_req, dmem_we, dmem_rvalid, fetch_valid, fetch_instr_valid;
  logic fc_valid, fc_rvalid, data_corr_irq, data_uncorr_irq, prog_corr_irq;
  logic prog_uncorr_irq, ecc_soft_reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [10:0] dmem_addr;
  logic [7:0] dmem_wdata, dmem_rdata, fetch_instr, m_instr;
  logic [15:0] fetch_addr, fetch_word, fc_word, fc_rdata, m_flip;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_mismatch, samples_checked;
  mem_ecc_monitor dut (.*);
  mem_ecc_flash_model u_flash (.clk(clk), .req(fetch_valid | fc_valid), .instr(m_instr),
    .flip(m_flip), .word(fetch_word));
  assign fc_word = fetch_word;
  always #12.5 clk = ~clk;
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= {14'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= {14'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, {er, 24'h0, e});
  endtask
  task automatic ft(input logic [15:0] a, input logic [7:0] i, input logic [15:0] f,
                    input logic ci, input logic rs);
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    m_instr <= i;
    m_flip <= f;
    @(posedge clk);
    fetch_valid <= 1'b0;
    #1;
    chk({fetch_instr_valid, ecc_soft_reset}, {1'b1, rs});
    if (ci) chk(fetch_instr, i);
  endtask
  task automatic fc(input logic [15:0] f, input logic [15:0] e);
    @(posedge clk);
    fc_valid <= 1'b1;
    m_instr <= 8'h00;
    m_flip <= f;
    @(posedge clk);
    fc_valid <= 1'b0;
    #1;
    chk({fc_rvalid, fc_rdata}, {1'b1, e});
  endtask
  task automatic dm(input logic we, input logic [10:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    dmem_req <= 1'b1;
    dmem_we <= we;
    dmem_addr <= a;
    dmem_wdata <= d;
    @(posedge clk);
    dmem_req <= 1'b0;
    k = 0;
    while (!we && dmem_rvalid !== 1'b1 && k < 4) begin
      @(posedge clk);
      k++;
    end
    if (!we) chk({k < 4, dmem_rdata}, {1'b1, d});
  endtask
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    s_axi_wstrb = 4'hF;
    {dmem_req, dmem_we, fetch_valid, fc_valid, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {dmem_addr, dmem_wdata, fetch_addr, m_instr, m_flip} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(mem_ecc_pkg::PCFG_IDX, 8'h80, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::PADL_IDX, 8'h00, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::PADH_IDX, 8'h00, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::DCFG_IDX, 8'h80, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::DADL_IDX, 8'h00, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::DADH_IDX, 8'h80, mem_ecc_pkg::RESP_OKAY);
    rd(16'h0000, 8'h00, mem_ecc_pkg::RESP_SLVERR);
    wr(16'h0000, 8'hFF, mem_ecc_pkg::RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    wr(mem_ecc_pkg::DCFG_IDX, 8'h00, mem_ecc_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(mem_ecc_pkg::DCFG_IDX, 8'h80, mem_ecc_pkg::RESP_OKAY);
    wr(mem_ecc_pkg::DCFG_IDX, 8'hFF, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::DCFG_IDX, 8'hB0, mem_ecc_pkg::RESP_OKAY);
    wr(mem_ecc_pkg::DCFG_IDX, 8'h80, mem_ecc_pkg::RESP_OKAY);
    dm(1'b1, 11'h7FF, 8'h5A);
    dm(1'b1, 11'h000, 8'hA5);
    dm(1'b0, 11'h7FF, 8'h5A);
    dm(1'b0, 11'h000, 8'hA5);
    rd(mem_ecc_pkg::DCFG_IDX, 8'h80, mem_ecc_pkg::RESP_OKAY);
    wr(mem_ecc_pkg::DCFG_IDX, 8'h00, mem_ecc_pkg::RESP_OKAY);
    dm(1'b1, 11'h7FF, 8'h5B);
    dm(1'b1, 11'h000, 8'hA6);
    wr(mem_ecc_pkg::DCFG_IDX, 8'hB0, mem_ecc_pkg::RESP_OKAY);
    dm(1'b0, 11'h7FF, 8'h5A);
    rd(mem_ecc_pkg::DCFG_IDX, 8'hB1, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::DADL_IDX, 8'hFF, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::DADH_IDX, 8'h07, mem_ecc_pkg::RESP_OKAY);
    chk({data_corr_irq, data_uncorr_irq}, 2'h2);
    dm(1'b0, 11'h000, 8'hA6);
    rd(mem_ecc_pkg::DCFG_IDX, 8'hB3, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::DADL_IDX, 8'hFF, mem_ecc_pkg::RESP_OKAY);
    chk({data_corr_irq, data_uncorr_irq}, 2'h3);
    dm(1'b1, 11'h7FF, 8'h5A);
    wr(mem_ecc_pkg::DCFG_IDX, 8'hB0, mem_ecc_pkg::RESP_OKAY);
    dm(1'b0, 11'h7FF, 8'h5A);
    dm(1'b0, 11'h000, 8'hA6);
    rd(mem_ecc_pkg::DCFG_IDX, 8'hB2, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::DADL_IDX, 8'h00, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::DADH_IDX, 8'h00, mem_ecc_pkg::RESP_OKAY);
    chk({data_corr_irq, data_uncorr_irq}, 2'h1);
    wr(mem_ecc_pkg::DCFG_IDX, 8'h80, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::DCFG_IDX, 8'h80, mem_ecc_pkg::RESP_OKAY);
    ft(16'hFFFF, 8'hA5, 16'h0010, 1'b1, 1'b0);
    rd(mem_ecc_pkg::PCFG_IDX, 8'h81, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::PADL_IDX, 8'hFF, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::PADH_IDX, 8'h3F, mem_ecc_pkg::RESP_OKAY);
    chk(prog_corr_irq, 1'b0);
    wr(mem_ecc_pkg::PCFG_IDX, 8'h91, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::PCFG_IDX, 8'h91, mem_ecc_pkg::RESP_OKAY);
    chk(prog_corr_irq, 1'b1);
    wr(mem_ecc_pkg::PCFG_IDX, 8'h90, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::PCFG_IDX, 8'h90, mem_ecc_pkg::RESP_OKAY);
    chk(prog_corr_irq, 1'b0);
    ft(16'h1234, 8'h3C, 16'h0300, 1'b0, 1'b0);
    rd(mem_ecc_pkg::PCFG_IDX, 8'h92, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::PADL_IDX, 8'h34, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::PADH_IDX, 8'h12, mem_ecc_pkg::RESP_OKAY);
    chk(prog_uncorr_irq, 1'b0);
    wr(mem_ecc_pkg::PCFG_IDX, 8'hA2, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::PCFG_IDX, 8'hA2, mem_ecc_pkg::RESP_OKAY);
    chk(prog_uncorr_irq, 1'b1);
    wr(mem_ecc_pkg::PCFG_IDX, 8'h80, mem_ecc_pkg::RESP_OKAY);
    ft(16'h0042, 8'h5A, 16'h0011, 1'b1, 1'b0);
    rd(mem_ecc_pkg::PCFG_IDX, 8'h81, mem_ecc_pkg::RESP_OKAY);
    wr(mem_ecc_pkg::RCMD_IDX, 8'h40, mem_ecc_pkg::RESP_OKAY);
    wr(mem_ecc_pkg::PCFG_IDX, 8'hA0, mem_ecc_pkg::RESP_OKAY);
    ft(16'h0043, 8'h00, 16'h0003, 1'b0, 1'b1);
    rd(mem_ecc_pkg::PCFG_IDX, 8'hA2, mem_ecc_pkg::RESP_OKAY);
    chk(prog_uncorr_irq, 1'b0);
    rd(mem_ecc_pkg::RCMD_IDX, 8'h04, mem_ecc_pkg::RESP_OKAY);
    wr(mem_ecc_pkg::RCMD_IDX, 8'h10, mem_ecc_pkg::RESP_OKAY);
    rd(mem_ecc_pkg::RCMD_IDX, 8'h00, mem_ecc_pkg::RESP_OKAY);
    wr(mem_ecc_pkg::PCFG_IDX, 8'h80, mem_ecc_pkg::RESP_OKAY);
    fc(16'h0001, 16'h0000);
    wr(mem_ecc_pkg::PCFG_IDX, 8'h00, mem_ecc_pkg::RESP_OKAY);
    fc(16'h0001, 16'h0001);
    chk({data_corr_irq, data_uncorr_irq}, 2'h0);
    report_and_stop;
  end
endmodule
